// ---- core/quad_decoder.v ----
`timescale 1ns/1ps
`include "servo_enc_defs.vh"

module quad_decoder
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // synchronised channels
  input wire chan_a,
  input wire chan_b,
  // count results
  output reg [`POS_W-1:0] position_r,
  output reg count_pulse_r,
  output reg count_dir_r
);

  reg a_prev_r;
  reg b_prev_r;
  reg [`POS_W-1:0] position_nxt;
  reg step;
  reg up;

  // --------------------------------------------------------------
  // x4 decode
  // --------------------------------------------------------------
  // both channels flipping together is illegal quadrature and is dropped
  always @*
  begin
    step = (chan_a ^ a_prev_r) ^ (chan_b ^ b_prev_r); // R4
    // a leading b counts up: new a differs from old b
    up = chan_a ^ b_prev_r; // R5
    position_nxt = position_r;
    if (step)
    begin
      if (up)
        position_nxt = position_r + `POS_W'd1;
      else
        position_nxt = position_r - `POS_W'd1;
    end
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
      position_r <= `POS_RST;
      count_pulse_r <= 1'b0;
      count_dir_r <= 1'b0;
    end
    else
    begin
      a_prev_r <= chan_a;
      b_prev_r <= chan_b;
      position_r <= position_nxt;
      count_pulse_r <= step;
      count_dir_r <= step ? up : count_dir_r;
    end
  end

endmodule // quad_decoder

// ---- core/servo_amp_and_encoder_interface.v ----
`timescale 1ns/1ps
`include "servo_enc_defs.vh"

// Functional notes
// R1: amplifier-enable output on enables the amplifier, off disables it.
// R2: enable output only turns on while sampled amplifier status is good.
// R3: amplifier asserts status when ready, releases it on power-off or fault.
// R4: count once per edge of A or B, four counts per line.
// R5: A leading B means clockwise, counted positive.
// R6: two independent decoders: feedback with index, auxiliary with A and B.
// R7: count correctly up to 250 kHz per channel with 22.5 degree phase error.
// R8: index recognised only while index high and A high together.
// R9: all encoder and status inputs pass two flip-flops before use.

module servo_amp_and_encoder_interface
(
  // clock and reset
  input wire core_clk,
  input wire rst,
  // amplifier
  input wire amp_enable_req,
  input wire amp_status_in,
  output reg amp_enable_out_r,
  output reg amp_fault_r,
  // feedback encoder pins
  input wire fb_enc_a,
  input wire fb_enc_b,
  input wire fb_enc_index,
  // auxiliary encoder pins
  input wire aux_enc_a,
  input wire aux_enc_b,
  // index capture control
  input wire index_arm,
  // feedback results
  output wire [`POS_W-1:0] fb_position,
  output wire fb_count_pulse,
  output wire fb_count_dir,
  output reg index_pulse_r,
  output reg index_captured_r,
  output reg [`POS_W-1:0] index_position_r,
  // auxiliary results
  output wire [`POS_W-1:0] aux_position,
  output wire aux_count_pulse,
  output wire aux_count_dir,
  // input quality
  output reg edge_rate_err_r
);

  localparam NUM_IN = 6;
  // the timing macro is a 32-bit integer; only its low half is needed
  localparam [31:0] MIN_EDGE_W = `ENC_MIN_EDGE_CYC;
  localparam [15:0] MIN_EDGE = MIN_EDGE_W[15:0];

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  wire [NUM_IN-1:0] raw_in;
  reg [NUM_IN-1:0] sync1_r;
  reg [NUM_IN-1:0] sync2_r;

  assign raw_in = {amp_status_in, fb_enc_index, aux_enc_b, aux_enc_a, fb_enc_b, fb_enc_a};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi = gi + 1)
    begin : g_sync
      always @(posedge core_clk)
      begin
        if (rst)
        begin
          sync1_r[gi] <= 1'b0; // R9
          sync2_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= raw_in[gi]; // R9
          sync2_r[gi] <= sync1_r[gi]; // R9
        end
      end
    end
  endgenerate

  wire fb_a_s = sync2_r[0];
  wire fb_b_s = sync2_r[1];
  wire aux_a_s = sync2_r[2];
  wire aux_b_s = sync2_r[3];
  wire idx_s = sync2_r[4];
  wire status_s = sync2_r[5];

  // --------------------------------------------------------------
  // amplifier enable
  // --------------------------------------------------------------
  // status loss drops enable at once; the amplifier stays off until the
  // request is withdrawn and reissued, so a flickering status cannot
  // toggle the drive on and off
  reg amp_enable_nxt;
  reg amp_fault_nxt;

  always @*
  begin
    amp_enable_nxt = amp_enable_out_r;
    amp_fault_nxt = amp_fault_r;
    if (!amp_enable_req)
    begin
      amp_enable_nxt = 1'b0; // R1
      amp_fault_nxt = 1'b0;
    end
    else if (!status_s)
    begin
      amp_enable_nxt = 1'b0; // R2
      amp_fault_nxt = amp_enable_out_r | amp_fault_r;
    end
    else if (!amp_fault_r)
      amp_enable_nxt = 1'b1; // R1
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      amp_enable_out_r <= 1'b0;
      amp_fault_r <= 1'b0;
    end
    else
    begin
      amp_enable_out_r <= amp_enable_nxt;
      amp_fault_r <= amp_fault_nxt;
    end
  end

  // --------------------------------------------------------------
  // decoders
  // --------------------------------------------------------------
  quad_decoder u_fb_dec // R6
  (
    .core_clk(core_clk),
    .rst(rst),
    .chan_a(fb_a_s),
    .chan_b(fb_b_s),
    .position_r(fb_position),
    .count_pulse_r(fb_count_pulse),
    .count_dir_r(fb_count_dir)
  );

  quad_decoder u_aux_dec // R6
  (
    .core_clk(core_clk),
    .rst(rst),
    .chan_a(aux_a_s),
    .chan_b(aux_b_s),
    .position_r(aux_position),
    .count_pulse_r(aux_count_pulse),
    .count_dir_r(aux_count_dir)
  );

  // --------------------------------------------------------------
  // index gating
  // --------------------------------------------------------------
  // the gated level rises once per revolution; its edge is the home mark
  reg idx_gate_r;
  wire idx_gate = idx_s & fb_a_s; // R8

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      idx_gate_r <= 1'b0;
      index_pulse_r <= 1'b0;
      index_captured_r <= 1'b0;
      index_position_r <= `POS_RST;
    end
    else
    begin
      idx_gate_r <= idx_gate;
      index_pulse_r <= idx_gate & ~idx_gate_r; // R8
      // a mark is taken only while none is held, so with a capture held, re-arming in the same cycle as a new mark wins and clears it
      if (idx_gate & ~idx_gate_r & ~index_captured_r)
      begin
        index_captured_r <= 1'b1;
        index_position_r <= fb_position;
      end
      else if (index_arm)
        index_captured_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // edge rate monitor
  // --------------------------------------------------------------
  // flags feedback edges two or more cycles closer than the least legal spacing; with
  // 100 MHz sampling the decoder itself keeps up far beyond that
  // the gap starts saturated, so the first edge after reset is never
  // mistaken for a burst
  reg [15:0] gap_r;
  reg [15:0] gap_nxt;
  reg edge_rate_err_nxt;

  always @*
  begin
    gap_nxt = gap_r;
    edge_rate_err_nxt = edge_rate_err_r;
    if (fb_count_pulse)
    begin
      gap_nxt = 16'h0000;
      if (gap_r < MIN_EDGE - 16'h0002)
        edge_rate_err_nxt = 1'b1; // R7
    end
    else if (gap_r != 16'hffff)
      gap_nxt = gap_r + 16'h0001;
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      gap_r <= 16'hffff;
      edge_rate_err_r <= 1'b0;
    end
    else
    begin
      gap_r <= gap_nxt;
      edge_rate_err_r <= edge_rate_err_nxt;
    end
  end

endmodule // servo_amp_and_encoder_interface

// ---- core/servo_enc_defs.vh ----
`ifndef SERVO_ENC_DEFS_VH
`define SERVO_ENC_DEFS_VH

// clock and encoder timing
`define CLK_FREQ_HZ 100000000
`define ENC_MAX_RATE_HZ 250000
// phase error in tenths of a degree
`define ENC_PHASE_ERR_DECI_DEG 225
// least edge spacing at full rate: quarter period shrunk by phase error, in ns
// period 4 us, quarter 1 us, minus 22.5/360 of the period = 0.75 us
`define ENC_MIN_EDGE_NS ((1000000000 / `ENC_MAX_RATE_HZ) / 4 - \
  ((1000000000 / `ENC_MAX_RATE_HZ) * `ENC_PHASE_ERR_DECI_DEG) / 3600)
`define CLK_PERIOD_NS (1000000000 / `CLK_FREQ_HZ)
`define ENC_MIN_EDGE_CYC (`ENC_MIN_EDGE_NS / `CLK_PERIOD_NS)

// widths and reset values
`define POS_W 32
`define POS_RST 32'h0000_0000
`define SYNC_STAGES 2

`endif

// ---- test/enc_amp_model.sv ----
`timescale 1ns/1ps
module enc_amp_model (
  input logic core_clk,
  output logic fa, fb, fi, xa, xb, st
);
  logic [1:0] ph [2] = '{2'h0, 2'h0};
  logic [1:0] lvl = 2'h0;
  // gray order 00,10,11,01 on (a,b): counting up lets a lead b
  assign fa = ph[0][1] ^ ph[0][0];
  assign fb = ph[0][1];
  assign xa = ph[1][1] ^ ph[1][0];
  assign xb = ph[1][1];
  assign fi = lvl[1];
  // an open status line reads inactive
  assign st = lvl[0];
  task automatic step(input int u, input bit up, input int n);
    @(posedge core_clk);
    ph[u] <= ph[u] + (up ? 2'h1 : 2'h3);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pin(input int k, input bit v);
    @(posedge core_clk);
    lvl[k] <= v;
  endtask
endmodule // enc_amp_model

// ---- test/servo_amp_and_encoder_interface_assertions.sv ----
`timescale 1ns/1ps
module amp_enc_chk (
  input logic core_clk, rst, amp_enable_req, amp_status_in, amp_enable_out_r, amp_fault_r,
  input logic fb_enc_a, fb_enc_b, fb_enc_index, aux_enc_a, aux_enc_b, index_pulse_r,
  input logic fb_count_pulse, fb_count_dir, aux_count_pulse, aux_count_dir,
  input logic [31:0] fb_position
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // exactly one channel moved; both at once is refused
  sequence s_edge; $changed(fb_enc_a) ^ $changed(fb_enc_b); endsequence
  property p_on; $rose(amp_enable_out_r) |-> $past(amp_status_in, 3); endproperty
  a_on: assert property (p_on) else $error("enable without status");
  property p_off; !amp_enable_req |=> !amp_enable_out_r; endproperty
  a_off: assert property (p_off) else $error("enable without request");
  property p_loss; $fell(amp_status_in) && amp_enable_out_r |-> ##[1:3] !amp_enable_out_r && amp_fault_r; endproperty
  a_loss: assert property (p_loss) else $error("enable kept after loss");
  property p_cnt; s_edge |-> ##3 fb_count_pulse; endproperty
  a_cnt: assert property (p_cnt) else $error("edge not counted");
  property p_dir; fb_count_pulse |-> fb_count_dir == ($past(fb_enc_a, 3) ^ $past(fb_enc_b, 4)); endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_pos;
    fb_count_pulse |-> fb_position == $past(fb_position) + (fb_count_dir ? 32'h0000_0001 : 32'hffff_ffff);
  endproperty
  a_pos: assert property (p_pos) else $error("wrong step");
  property p_aux; aux_count_pulse |-> aux_count_dir == ($past(aux_enc_a, 3) ^ $past(aux_enc_b, 4)); endproperty
  a_aux: assert property (p_aux) else $error("wrong aux direction");
  property p_idx; index_pulse_r |-> $past(fb_enc_index, 3) && $past(fb_enc_a, 3); endproperty
  a_idx: assert property (p_idx) else $error("index without A");
  // index and A both high at the pins, the later of the two just risen
  sequence s_idx; $rose(fb_enc_index && fb_enc_a); endsequence
  property p_idx_rise; s_idx |-> ##3 index_pulse_r; endproperty
  a_idx_rise: assert property (p_idx_rise) else $error("index mark missed");
endmodule // amp_enc_chk

bind servo_amp_and_encoder_interface amp_enc_chk u_chk (.*);

// ---- test/servo_amp_and_encoder_interface_tb_top.sv ----
`timescale 1ns/1ps
module servo_amp_and_encoder_interface_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic arm = 1'b0;
  wire fa, fb, fi, xa, xb, st, en, flt, fp_p, fp_d, ip_p, cap, ap_p, ap_d, err;
  wire [31:0] fp, ip, ap;
  int mismatches, num_checks, u;
  logic [31:0] ep [2] = '{32'h0000_0000, 32'h0000_0000};
  logic [31:0] hold;
  bit up;
  always #5 core_clk = ~core_clk;
  enc_amp_model m (.core_clk(core_clk), .fa(fa), .fb(fb), .fi(fi), .xa(xa), .xb(xb), .st(st));
  servo_amp_and_encoder_interface DUT (.core_clk(core_clk), .rst(rst), .amp_enable_req(req),
    .amp_status_in(st), .amp_enable_out_r(en), .amp_fault_r(flt), .fb_enc_a(fa), .fb_enc_b(fb),
    .fb_enc_index(fi), .aux_enc_a(xa), .aux_enc_b(xb), .index_arm(arm), .fb_position(fp),
    .fb_count_pulse(fp_p), .fb_count_dir(fp_d), .index_pulse_r(ip_p), .index_captured_r(cap),
    .index_position_r(ip), .aux_position(ap), .aux_count_pulse(ap_p), .aux_count_dir(ap_d),
    .edge_rate_err_r(err));
  function logic [31:0] nxt(input logic [31:0] p, input bit up);
    return p + (up ? 32'h0000_0001 : 32'hffff_ffff);
  endfunction
  // sample after the edge's updates have landed
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    #1;
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  initial
  begin
    tick(20000);
    mismatches++;
    report_and_stop;
  end
  // --------
  // tests
  // --------
  initial
  begin
    void'($urandom(32'heb39_9837));
    tick(12);
    rst <= 1'b0;
    @(posedge core_clk) req <= 1'b1;
    tick(6);
    chk("enable", 32'(en), 32'h0);
    m.pin(0, 1'b1);
    tick(5);
    chk("enable", 32'(en), 32'h1);
    m.pin(0, 1'b0);
    tick(5);
    chk("enable", 32'(en), 32'h0);
    chk("fault", 32'(flt), 32'h1);
    m.pin(0, 1'b1);
    @(posedge core_clk) req <= 1'b0;
    @(posedge core_clk) req <= 1'b1;
    tick(3);
    chk("enable", 32'(en), 32'h1);
    chk("fault", 32'(flt), 32'h0);
    $display("amplifier test done");
    repeat (40)
    begin
      u = $urandom % 2;
      up = $urandom % 2;
      m.step(u, up, 75);
      ep[u] = nxt(ep[u], up);
      chk(u ? "aux position" : "fb position", u ? ap : fp, ep[u]);
    end
    $display("count test done");
    while (ep[0][1:0] !== 2'h0)
    begin
      m.step(0, 1'b1, 75);
      ep[0] = nxt(ep[0], 1'b1);
    end
    @(posedge core_clk) arm <= 1'b1;
    @(posedge core_clk) arm <= 1'b0;
    m.pin(1, 1'b1);
    tick(5);
    chk("captured", 32'(cap), 32'h0);
    hold = ep[0];
    m.step(0, 1'b1, 75);
    ep[0] = nxt(ep[0], 1'b1);
    chk("captured", 32'(cap), 32'h1);
    chk("index position", ip, hold);
    chk("rate error", 32'(err), 32'h0);
    @(posedge core_clk) req <= 1'b0;
    tick(2);
    chk("enable", 32'(en), 32'h0);
    $display("index test done");
    // two edges 11 cycles apart: still counted, but flagged as too fast
    m.step(0, 1'b1, 10);
    m.step(0, 1'b1, 75);
    ep[0] = nxt(nxt(ep[0], 1'b1), 1'b1);
    chk("fb position", fp, ep[0]);
    chk("rate error", 32'(err), 32'h1);
    while (ep[0][1:0] !== 2'h0 || ep[1][1:0] !== 2'h0)
    begin
      u = (ep[0][1:0] !== 2'h0) ? 0 : 1;
      m.step(u, 1'b1, 75);
      ep[u] = nxt(ep[u], 1'b1);
    end
    // mid-run reset with A and B of both encoders low and the index still high, so no false edge follows
    @(posedge core_clk) rst <= 1'b1;
    tick(12);
    rst <= 1'b0;
    ep[0] = 32'h0000_0000;
    ep[1] = 32'h0000_0000;
    tick(2);
    chk("rate error", 32'(err), 32'h0);
    chk("captured", 32'(cap), 32'h0);
    chk("fb position", fp, ep[0]);
    chk("aux position", ap, ep[1]);
    m.step(0, 1'b1, 75);
    ep[0] = nxt(ep[0], 1'b1);
    chk("fb position", fp, ep[0]);
    chk("rate error", 32'(err), 32'h0);
    chk("captured", 32'(cap), 32'h1);
    chk("index position", ip, 32'h0000_0000);
    m.step(1, 1'b0, 75);
    ep[1] = nxt(ep[1], 1'b0);
    chk("aux position", ap, ep[1]);
    $display("reset test done");
    report_and_stop;
  end
endmodule // servo_amp_and_encoder_interface_tb_top
